/* File: hdl/rtdp_pkg.sv */
// Purpose: shared constants and types of the ram test data port
// Assumes: 32-bit apb data, one register per aligned word
// Notes:   every offset, field position, reset value and width lives here
package rtdp_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] RTDP_OFF_RAM_SELECT = 8'h40; // port_ram_select
   localparam logic [7:0] RTDP_OFF_COMMAND    = 8'h44; // port_command
   localparam logic [7:0] RTDP_OFF_ADDRESS    = 8'h48; // port_address
   localparam logic [7:0] RTDP_OFF_DATA_LOW   = 8'h4C; // port_data_low
   localparam logic [7:0] RTDP_OFF_DATA_HIGH  = 8'h50; // port_data_high

   // ----------------------------------------------------------------
   // field positions and widths
   // ----------------------------------------------------------------
   localparam int RTDP_TEST_EN_BIT  = 0;  // ram_test_mode_enable
   localparam int RTDP_RAM_TARGET_SELECT_LSB     = 1;  // ram_target_select low bit
   localparam int RTDP_RAM_TARGET_SELECT_W       = 2;  // ram_target_select width
   localparam int RTDP_READY_BIT    = 31; // port_ready_flag
   localparam int RTDP_CMD_WR_BIT   = 0;  // write / read select
   localparam int RTDP_ADDR_W       = 15; // dword address width
   localparam int RTDP_DATA_HI_W    = 5;  // data bits 36:32
   localparam int RTDP_RAM_W        = 37; // widest ram word
   localparam int RTDP_PADDR_W      = 8;  // decoded apb address width

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic                      RTDP_RST_TEST_EN = 1'h0;
   localparam logic [RTDP_RAM_TARGET_SELECT_W-1:0]    RTDP_RST_RAM_TARGET_SELECT    = 2'h0;
   localparam logic                      RTDP_RST_READY   = 1'h1;
   localparam logic                      RTDP_RST_CMD_WR  = 1'h0;
   localparam logic [RTDP_ADDR_W-1:0]    RTDP_RST_ADDR    = 15'h0000;
   localparam logic [31:0]               RTDP_RST_DATA_LO = 32'h0000_0000;
   localparam logic [RTDP_DATA_HI_W-1:0] RTDP_RST_DATA_HI = 5'h00;

   // ----------------------------------------------------------------
   // ram targets and sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RTDP_RAM_FIRST_DATA = 2'h0, // first_data_ram
      RTDP_RAM_NV_IMAGE   = 2'h1, // nonvolatile storage image ram
      RTDP_RAM_TX_XFER    = 2'h2, // tx_transfer_ram
      RTDP_RAM_RX_XFER    = 2'h3  // rx_transfer_ram
   } rtdp_ram_t;

   typedef enum logic [1:0] {
      RTDP_ST_IDLE,
      RTDP_ST_BUSY,
      RTDP_ST_FINISH
   } rtdp_state_t;

endpackage

/* File: hdl/rtdp_acc_if.sv */
// Purpose: carrier between register bank and access sequencer
// Assumes: single clock domain
// Notes:   start is a one-cycle pulse, rd_valid likewise
`timescale 1ns/10ps
`default_nettype none
interface rtdp_acc_if;
   import rtdp_pkg::*;
   logic                  start;    // begin one access
   logic                  write;    // 1 write, 0 read
   rtdp_ram_t             sel;      // target ram
   logic [RTDP_ADDR_W-1:0] addr;    // dword address
   logic [RTDP_RAM_W-1:0] wdata;    // write word
   logic                  ready;    // port idle
   logic                  rd_valid; // read word present
   logic [RTDP_RAM_W-1:0] rd_data;  // read word

   modport regs (output start, write, sel, addr, wdata,
                 input ready, rd_valid, rd_data);
   modport seq  (input start, write, sel, addr, wdata,
                 output ready, rd_valid, rd_data);
endinterface
`default_nettype wire

/* File: hdl/rtdp_seq.sv */
// Purpose: runs one ram access per start pulse and reports ready
// Assumes: ram_ack from logic on the same clock, held req until ack
// Notes:   ready stays low through a finish cycle so read data lands first
`timescale 1ns/10ps
`default_nettype none
module rtdp_seq
   import rtdp_pkg::*;
(
   input  wire logic                   clock,
   input  wire logic                   reset,
   input  wire logic                   clock_en,
   rtdp_acc_if.seq                     acc,
   output logic                        ram_req,
   output logic                        ram_we,
   output rtdp_ram_t                   ram_sel,
   output logic [RTDP_ADDR_W-1:0]      ram_addr,
   output logic [RTDP_RAM_W-1:0]       ram_wdata,
   input  wire logic                   ram_ack,
   input  wire logic [RTDP_RAM_W-1:0]  ram_rdata
);

   typedef struct packed {
      rtdp_state_t           st;     // sequencer state
      logic                  ready;  // port_ready_flag
      logic                  req;    // ram request
      logic                  we;     // ram write enable
      rtdp_ram_t             sel;    // latched target
      logic [RTDP_ADDR_W-1:0] addr;  // latched address
      logic [RTDP_RAM_W-1:0] wdata;  // latched write word
      logic                  rvalid; // read word valid pulse
      logic [RTDP_RAM_W-1:0] rdata;  // captured read word
   } rtdp_seq_t;

   rtdp_seq_t s_r;   // registered state
   rtdp_seq_t s_nxt; // next state

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt        = s_r;
      s_nxt.rvalid = 1'b0;
      case (s_r.st)
         RTDP_ST_IDLE: begin
            // latch everything so later register writes cannot disturb it
            if (acc.start) begin
               s_nxt.st    = RTDP_ST_BUSY;
               s_nxt.ready = 1'b0;
               s_nxt.req   = 1'b1;
               s_nxt.we    = acc.write;
               s_nxt.sel   = acc.sel;
               s_nxt.addr  = acc.addr;
               s_nxt.wdata = acc.wdata;
            end
         end
         RTDP_ST_BUSY: begin
            // request holds until the ram acknowledges
            if (ram_ack) begin
               s_nxt.st     = RTDP_ST_FINISH;
               s_nxt.req    = 1'b0;
               s_nxt.we     = 1'b0;
               s_nxt.rvalid = ~s_r.we;
               s_nxt.rdata  = ram_rdata;
            end
         end
         RTDP_ST_FINISH: begin
            // data registers take rdata at this edge, ready rises with it
            s_nxt.st    = RTDP_ST_IDLE;
            s_nxt.ready = 1'b1;
         end
         default: begin
            s_nxt.st    = RTDP_ST_IDLE;
            s_nxt.ready = 1'b1;
            s_nxt.req   = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         s_r        <= '0;
         s_r.st     <= RTDP_ST_IDLE;
         s_r.ready  <= RTDP_RST_READY;
      end else if (clock_en) begin
         s_r <= s_nxt;
      end
   end

   assign acc.ready    = s_r.ready;
   assign acc.rd_valid = s_r.rvalid;
   assign acc.rd_data  = s_r.rdata;
   assign ram_req      = s_r.req;
   assign ram_we       = s_r.we;
   assign ram_sel      = s_r.sel;
   assign ram_addr     = s_r.addr;
   assign ram_wdata    = s_r.wdata;

endmodule
`default_nettype wire

/* File: hdl/rtdp_top.sv */
// Purpose: apb register bank of the ram test data port
// Assumes: apb3 master, internal rams acknowledge on this clock
// Notes:   zero-wait apb answer, one access in flight at a time
//
// Functional notes
// - test enable bit puts rams in test
// - two-bit select picks one of four rams
// - ready flag bit 31 shows idle
// - ready flag resets to one
// - ready rises only after access completes
// - read data stored at the edge where ready rises
// - command write starts access, bit selects direction
// - fifteen-bit dword address, resets to zero
// - low data register: write source, read result
// - high data register carries bits 36:32
`timescale 1ns/10ps
`default_nettype none
module rtdp_top
   import rtdp_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic                    reset,
   input  wire logic                    clock_en,
   // apb slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [RTDP_PADDR_W-1:0] paddr,
   input  wire logic [31:0]             pwdata,
   output logic [31:0]                  prdata,
   output logic                         pready,
   output logic                         pslverr,
   // ram test port
   output logic                         ram_test_mode_enable,
   output logic                         ram_req,
   output logic                         ram_we,
   output rtdp_ram_t                    ram_sel,
   output logic [RTDP_ADDR_W-1:0]       ram_addr,
   output logic [RTDP_RAM_W-1:0]        ram_wdata,
   input  wire logic                    ram_ack,
   input  wire logic [RTDP_RAM_W-1:0]   ram_rdata
);

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------

   // true when the bus address names the given register
   function automatic logic rtdp_hit(input logic [RTDP_PADDR_W-1:0] a,
                                     input logic [7:0]              off);
      rtdp_hit = (a == off);
   endfunction

   // true when the bus address names any register of the bank
   function automatic logic rtdp_mapped(input logic [RTDP_PADDR_W-1:0] a);
      rtdp_mapped = rtdp_hit(a, RTDP_OFF_RAM_SELECT) |
                    rtdp_hit(a, RTDP_OFF_COMMAND)    |
                    rtdp_hit(a, RTDP_OFF_ADDRESS)    |
                    rtdp_hit(a, RTDP_OFF_DATA_LOW)   |
                    rtdp_hit(a, RTDP_OFF_DATA_HIGH);
   endfunction

   // ----------------------------------------------------------------
   // state of the bank
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                     test_en; // ram_test_mode_enable
      rtdp_ram_t                ram_target_select;    // ram_target_select
      logic                     cmd_wr;  // direction of the last accepted command
      logic [RTDP_ADDR_W-1:0]   addr;    // port_address
      logic [31:0]              data_lo; // port_data_low
      logic [RTDP_DATA_HI_W-1:0] data_hi; // port_data_high
      logic                     pready;  // apb answer
      logic                     pslverr; // apb error
      logic [31:0]              prdata;  // apb read word
   } rtdp_regs_t;

   rtdp_regs_t r_r;   // registered bank
   rtdp_regs_t r_nxt; // next bank

   rtdp_acc_if acc (); // link to the access sequencer

   logic setup_ph;  // apb setup cycle
   logic access_ok; // apb access completing this edge
   logic wr_done;   // write takes effect this edge

   // ----------------------------------------------------------------
   // apb phase decode
   // ----------------------------------------------------------------

   // pready is raised in the setup cycle so every access ends in one
   assign setup_ph  = psel & ~penable;
   assign access_ok = psel & penable & r_r.pready;
   assign wr_done   = access_ok & pwrite & rtdp_mapped(paddr);

   // ----------------------------------------------------------------
   // command start towards the sequencer
   // ----------------------------------------------------------------

   // a command written while busy is dropped: the in-flight access
   // keeps its latched operands, and software sees ready still low
   assign acc.start = wr_done & rtdp_hit(paddr, RTDP_OFF_COMMAND)
                      & acc.ready;
   assign acc.write = pwdata[RTDP_CMD_WR_BIT];
   assign acc.sel   = r_r.ram_target_select;
   assign acc.addr  = r_r.addr;
   assign acc.wdata = {r_r.data_hi, r_r.data_lo};

   // ----------------------------------------------------------------
   // next value of the bank
   // ----------------------------------------------------------------
   always_comb begin
      r_nxt         = r_r;
      r_nxt.pready  = 1'b0;
      r_nxt.pslverr = 1'b0;

      // answer prepared in setup, presented through the access phase
      if (setup_ph) begin
         r_nxt.pready  = 1'b1;
         r_nxt.pslverr = ~rtdp_mapped(paddr);
         r_nxt.prdata  = 32'h0000_0000;
         if (!pwrite) begin
            if (rtdp_hit(paddr, RTDP_OFF_RAM_SELECT)) begin
               // reserved bits stay zero
               r_nxt.prdata[RTDP_READY_BIT]  = acc.ready;
               r_nxt.prdata[RTDP_RAM_TARGET_SELECT_LSB+:RTDP_RAM_TARGET_SELECT_W] = r_r.ram_target_select;
               r_nxt.prdata[RTDP_TEST_EN_BIT] = r_r.test_en;
            end else if (rtdp_hit(paddr, RTDP_OFF_COMMAND)) begin
               r_nxt.prdata[RTDP_CMD_WR_BIT] = r_r.cmd_wr;
            end else if (rtdp_hit(paddr, RTDP_OFF_ADDRESS)) begin
               r_nxt.prdata[RTDP_ADDR_W-1:0] = r_r.addr;
            end else if (rtdp_hit(paddr, RTDP_OFF_DATA_LOW)) begin
               r_nxt.prdata = r_r.data_lo;
            end else if (rtdp_hit(paddr, RTDP_OFF_DATA_HIGH)) begin
               r_nxt.prdata[RTDP_DATA_HI_W-1:0] = r_r.data_hi;
            end else begin
               // unmapped: zero data with slave error
               r_nxt.prdata = 32'h0000_0000;
            end
         end
      end

      // register writes, only the defined bits are stored
      if (wr_done) begin
         if (rtdp_hit(paddr, RTDP_OFF_RAM_SELECT)) begin
            r_nxt.test_en = pwdata[RTDP_TEST_EN_BIT];
            r_nxt.ram_target_select    = rtdp_ram_t'(pwdata[RTDP_RAM_TARGET_SELECT_LSB+:RTDP_RAM_TARGET_SELECT_W]);
         end
         if (acc.start) begin
            r_nxt.cmd_wr = pwdata[RTDP_CMD_WR_BIT];
         end
         if (rtdp_hit(paddr, RTDP_OFF_ADDRESS)) begin
            r_nxt.addr = pwdata[RTDP_ADDR_W-1:0];
         end
         if (rtdp_hit(paddr, RTDP_OFF_DATA_LOW)) begin
            r_nxt.data_lo = pwdata;
         end
         if (rtdp_hit(paddr, RTDP_OFF_DATA_HIGH)) begin
            r_nxt.data_hi = pwdata[RTDP_DATA_HI_W-1:0];
         end
      end

      // read result lands in the data registers at the edge where ready rises;
      // it wins over a bus write in the same cycle so the result is kept
      if (acc.rd_valid) begin
         r_nxt.data_lo = acc.rd_data[31:0];
         r_nxt.data_hi = acc.rd_data[RTDP_RAM_W-1:32];
      end
   end

   // ----------------------------------------------------------------
   // bank register
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         r_r.test_en <= RTDP_RST_TEST_EN;
         r_r.ram_target_select    <= rtdp_ram_t'(RTDP_RST_RAM_TARGET_SELECT);
         r_r.cmd_wr  <= RTDP_RST_CMD_WR;
         r_r.addr    <= RTDP_RST_ADDR;
         r_r.data_lo <= RTDP_RST_DATA_LO;
         r_r.data_hi <= RTDP_RST_DATA_HI;
         r_r.pready  <= 1'b0;
         r_r.pslverr <= 1'b0;
         r_r.prdata  <= 32'h0000_0000;
      end else if (clock_en) begin
         r_r <= r_nxt;
      end
   end

   // ----------------------------------------------------------------
   // access sequencer
   // ----------------------------------------------------------------

   // the sequencer owns the ready flag and the ram handshake
   rtdp_seq u_seq (
      .clock     (clock),
      .reset     (reset),
      .clock_en  (clock_en),
      .acc       (acc.seq),
      .ram_req   (ram_req),
      .ram_we    (ram_we),
      .ram_sel   (ram_sel),
      .ram_addr  (ram_addr),
      .ram_wdata (ram_wdata),
      .ram_ack   (ram_ack),
      .ram_rdata (ram_rdata)
   );

   // ----------------------------------------------------------------
   // outputs, all straight from flip-flops
   // ----------------------------------------------------------------
   assign prdata               = r_r.prdata;
   assign pready               = r_r.pready;
   assign pslverr              = r_r.pslverr;
   assign ram_test_mode_enable = r_r.test_en;

endmodule
`default_nettype wire

/* File: test/rtdp_top_properties.sv */
// Purpose: protocol checks on the ram test data port
// Assumes: clock_en held high, port ready inferred from ram_req history
// Notes:   bound to the top module at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module rtdp_top_properties
   import rtdp_pkg::*;
(
   input wire logic                    clock,
   input wire logic                    reset,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [RTDP_PADDR_W-1:0] paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire logic                    ram_test_mode_enable,
   input wire logic                    ram_req,
   input wire logic                    ram_we,
   input wire logic                    ram_ack
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   logic mapped; // address hits one of the five registers
   assign mapped = paddr inside {RTDP_OFF_RAM_SELECT, RTDP_OFF_COMMAND, RTDP_OFF_ADDRESS,
                                 RTDP_OFF_DATA_LOW, RTDP_OFF_DATA_HIGH};
   // ----------------------------------------------------------------
   // sequences
   // ----------------------------------------------------------------
   sequence s_acc; // completing apb access
      psel && penable && pready;
   endsequence
   sequence s_cmd_idle; // command write while no access in flight or finishing
      s_acc ##0 pwrite && paddr == RTDP_OFF_COMMAND && !ram_req && !$past(ram_req);
   endsequence
   sequence s_rd(logic [7:0] off); // read of one register
      s_acc ##0 !pwrite && paddr == off;
   endsequence
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   a_zero_wait: assert property (psel && !penable |=> pready) else $error("pready late");
   a_pready_pulse: assert property (pready |=> !pready) else $error("pready stuck");
   a_err_unmapped: assert property (s_acc |-> pslverr == !mapped) else $error("pslverr wrong");
   a_unmapped_zero: assert property (s_acc ##0 !pwrite && !mapped |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_cmd_starts: assert property (s_cmd_idle |=> ram_req && ram_we == $past(pwdata[0]))
      else $error("command did not start access");
   a_req_holds: assert property (ram_req && !ram_ack |=> ram_req) else $error("ram_req dropped early");
   a_req_ends: assert property (ram_req && ram_ack |=> !ram_req [*2]) else $error("ram_req after ack");
   a_busy_flag: assert property (s_rd(RTDP_OFF_RAM_SELECT) ##0 $past(ram_req) |-> !prdata[31])
      else $error("ready high during access");
   a_test_mode: assert property (s_acc ##0 pwrite && paddr == RTDP_OFF_RAM_SELECT |=>
      ram_test_mode_enable == $past(pwdata[0])) else $error("test enable wrong");
   a_resv_zero: assert property (s_acc ##0 !pwrite |->
      (paddr != RTDP_OFF_ADDRESS || prdata[31:15] == 17'h0)
      && (paddr != RTDP_OFF_COMMAND || prdata[31:1] == 31'h0) && (paddr != RTDP_OFF_RAM_SELECT
      || prdata[30:3] == 28'h0) && (paddr != RTDP_OFF_DATA_HIGH || prdata[31:5] == 27'h0))
      else $error("reserved bits not zero");
endmodule
bind rtdp_top rtdp_top_properties u_props (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ram_test_mode_enable(ram_test_mode_enable), .ram_req(ram_req), .ram_we(ram_we), .ram_ack(ram_ack));
`default_nettype wire

/* File: test/ram_test_data_port_bench.sv */
// Purpose: self-checking bench for the ram test data port
// Assumes: clock_en tied high, ram answers after 0..3 cycles
// Notes:   expected results travel in queues to the watching processes
`timescale 1ns/10ps
`default_nettype none
module ram_test_data_port_bench;
   import rtdp_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic        clock, reset, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        test_en, ram_req, ram_we, ram_ack;
   rtdp_ram_t   ram_sel;
   logic [14:0] ram_addr, a;
   logic [36:0] ram_wdata, ram_rdata, dat;
   logic [33:0] nq[$];  // apb notes {check, err, data}
   logic [54:0] rq[$];  // ram notes {we, sel, addr, wdata}
   logic [33:0] nt;     // note under comparison
   logic [31:0] gw;     // read word of the unmapped-address transfer, checked by the watcher
   int          n_mismatch, compares, cycles, dly;
   rtdp_top dut (.clock(clock), .reset(reset), .clock_en(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ram_test_mode_enable(test_en), .ram_req(ram_req), .ram_we(ram_we),
      .ram_sel(ram_sel), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_ack(ram_ack),
      .ram_rdata(ram_rdata));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [36:0] rd_word(input logic [1:0] s, input logic [14:0] ad);
      return {s, ad, 20'hA5C3F}; // address-stamped so a wrong lane shows
   endfunction
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                      input logic c, input logic [32:0] e, output logic [31:0] g);
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= ad;
      pwdata  <= d;
      nq.push_back({c, e});
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      g = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      logic [31:0] g;
      apb(1'b1, ad, d, 1'b0, 33'h0, g);
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] e);
      logic [31:0] g;
      apb(1'b0, ad, 32'h0, 1'b1, {1'b0, e}, g);
   endtask
   task automatic poll; // bounded by the cycle ceiling
      logic [31:0] g;
      do apb(1'b0, RTDP_OFF_RAM_SELECT, 32'h0, 1'b0, 33'h0, g); while (g[31] !== 1'b1);
   endtask
   // ----------------------------------------------------------------
   // watchers: apb answers, ram stand-in, cycle ceiling
   // ----------------------------------------------------------------
   always @(posedge clock) begin
      if (psel && penable && pready === 1'b1) begin
         nt = nq.pop_front();
         if (nt[33]) chk("apb read", {31'h0, nt[32:0]}, {31'h0, pslverr, prdata});
      end
   end
   // ram answers after a random stall; data lines churn when idle
   // each signal gets one assignment per edge
   always @(posedge clock) begin
      if (ram_req === 1'b1 && !ram_ack && dly == 0) begin
         ram_ack   <= 1'b1;
         ram_rdata <= rd_word(ram_sel, ram_addr);
         dly       <= $urandom_range(3, 0);
         chk("ram op", {9'h0, rq.pop_front()},
             {9'h0, ram_we, ram_sel, ram_addr, ram_we ? ram_wdata : 37'h0});
      end else begin
         ram_ack   <= 1'b0;
         ram_rdata <= ~ram_rdata;
         if (ram_req === 1'b1 && !ram_ack)
            dly <= dly - 1;
      end
   end
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ram_ack = 1'b0;
      ram_rdata = 37'h0;
      n_mismatch = 0;
      compares = 0;
      cycles = 0;
      dly = 0;
      void'($urandom(37));
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      chk("test enable", 64'h0, {63'h0, test_en});
      rd(RTDP_OFF_RAM_SELECT, 32'h8000_0000);
      rd(RTDP_OFF_COMMAND, 32'h0);
      rd(RTDP_OFF_ADDRESS, 32'h0);
      rd(RTDP_OFF_DATA_LOW, 32'h0);
      rd(RTDP_OFF_DATA_HIGH, 32'h0);
      $display("test reset values done");
      wr(RTDP_OFF_RAM_SELECT, 32'hFFFF_FFFF);
      rd(RTDP_OFF_RAM_SELECT, 32'h8000_0007);
      chk("test enable", 64'h1, {63'h0, test_en});
      wr(RTDP_OFF_ADDRESS, 32'hFFFF_FFFF);
      rd(RTDP_OFF_ADDRESS, 32'h0000_7FFF);
      wr(RTDP_OFF_DATA_HIGH, 32'hFFFF_FFFF);
      rd(RTDP_OFF_DATA_HIGH, 32'h0000_001F);
      apb(1'b0, 8'h54, 32'h0, 1'b1, {1'b1, 32'h0}, gw);
      $display("test fields and reserved bits done");
      for (int s = 0; s < 4; s++) begin
         a   = 15'($urandom);
         dat = {5'($urandom), $urandom};
         wr(RTDP_OFF_RAM_SELECT, {29'h0, 2'(s), 1'b1});
         wr(RTDP_OFF_ADDRESS, {17'h0, a});
         wr(RTDP_OFF_DATA_LOW, dat[31:0]);
         wr(RTDP_OFF_DATA_HIGH, {27'h0, dat[36:32]});
         rq.push_back({1'b1, 2'(s), a, dat});
         wr(RTDP_OFF_COMMAND, 32'h1);
         wr(RTDP_OFF_COMMAND, 32'h0); // busy: must be dropped
         poll();
         rd(RTDP_OFF_COMMAND, 32'h1);
         a = a ^ 15'h5555;
         wr(RTDP_OFF_ADDRESS, {17'h0, a});
         rq.push_back({1'b0, 2'(s), a, 37'h0});
         wr(RTDP_OFF_COMMAND, 32'h0);
         rd(RTDP_OFF_RAM_SELECT, {29'h0, 2'(s), 1'b1});
         poll();
         dat = rd_word(2'(s), a);
         rd(RTDP_OFF_DATA_LOW, dat[31:0]);
         rd(RTDP_OFF_DATA_HIGH, {27'h0, dat[36:32]});
      end
      $display("test ram accesses done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
